// *** include/dram_mode_pkg.sv ***
// Constants for the mode and extended-mode register set logic.
// Assumes a single 100 MHz clock domain and synchronous command pins.
package dram_mode_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 10;
    localparam int MODE_LOAD_CYCLES    = 6;
    localparam int DLL_RESET_CYCLES    = 10;
    localparam int DLL_LOCK_CYCLES     = 20000;
    localparam int LP_SHORT_EXIT_TCK   = 300;
    localparam int LP_LONG_EXIT_TCK    = 20000;
    localparam int LP_LONG_US          = 20;
    localparam int LP_LONG_CYCLES      = LP_LONG_US * 1000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Mode register field positions
    // ------------------------------------------------------------
    localparam int MR_BURST_LSB  = 0;
    localparam int MR_READ_LSB   = 4;
    localparam int MR_TEST_BIT   = 7;
    localparam int MR_DLLRST_BIT = 8;
    localparam int MR_WRITE_LSB  = 9;

    // ------------------------------------------------------------
    // Extended mode register field positions
    // ------------------------------------------------------------
    localparam int EMR_DRIVE_LSB  = 0;
    localparam int EMR_TERM_LSB   = 2;
    localparam int EMR_ADDED_LSB  = 4;
    localparam int EMR_DLLOFF_BIT = 6;
    localparam int EMR_IMP_LSB    = 8;
    localparam int EMR_VENDOR_BIT = 10;
    localparam int EMR_LOWPWR_BIT = 11;

    // ------------------------------------------------------------
    // Latency ranges and codes
    // ------------------------------------------------------------
    localparam logic [3:0] READ_DELAY_MIN  = 4'h5;
    localparam logic [3:0] READ_DELAY_MAX  = 4'h9;
    localparam logic [3:0] WRITE_DELAY_MIN = 4'h1;
    localparam logic [3:0] WRITE_DELAY_MAX = 4'h6;
    localparam logic [3:0] RX_ALWAYS_ON_MAX = 4'h3;
    localparam logic [3:0] READ_DELAY_RST  = 4'h5;
    localparam logic [3:0] WRITE_DELAY_RST = 4'h1;

    // Termination codes: off, 60 ohm, 120 ohm
    localparam logic [1:0] TERM_OFF   = 2'h0;
    localparam logic [1:0] TERM_60    = 2'h1;
    localparam logic [1:0] TERM_120   = 2'h2;
    // Impedance code for 40 ohm autocalibration
    localparam logic [1:0] IMP_AUTOCAL = 2'h0;

    // Identity values, arbitrary
    localparam logic [3:0] MAKER_CODE = 4'hc;
    localparam logic [3:0] REV_CODE   = 4'h2;

    // Power states
    typedef enum logic [4:0]
    {
        PWR_ACTIVE = 5'h01,
        PWR_PDN    = 5'h02,
        PWR_LP1    = 5'h04,
        PWR_SREF   = 5'h08,
        PWR_LP2    = 5'h10
    } pwr_state_t;

endpackage

// *** rtl/dram_mode_register_set.sv ***
// Mode and extended-mode register set logic of a graphics DRAM.
// Assumes the command bus is sampled on mclk and the controller keeps
// its own timing obligations.
//
// Operation
// - Read delay setting accepted from 5 to 7 clocks (3-bit field); data at n+m.
// - Write delay setting accepted from 1 to 6 clocks; data at n+m.
// - Write delay 1..3 keeps data receivers permanently on.
// - A7 high enters test mode, low normal; other bits carry fields.
// - A8 high starts a DLL reset; low leaves the DLL alone.
// - DLL reset bit 8 self-clears when the reset completes.
// - Extended load: all strobes low, BA0 high, BA1 low; store A0-A6 and A8-A11.
// - Extended load completes in six clocks.
// - A1,A0 select one of four output driver strengths.
// - Self refresh exit re-enables the DLL automatically.
// - Termination select gives 60 ohm, 120 ohm or off.
// - Impedance autocal selects calibrated 40 ohm; others nominal.
// - Added read delay adds to read delay for total read latency.
// - A10 high drives maker code on DQ[3:0], revision on DQ[7:4].
// - A11 high routes power-down and self refresh to low-power states.
// - Mode load: all strobes low, both bank bits low; six clocks.
// - Mode fields: burst A0-A2, read A4-A6, A7, A8, write A9-A11.

`timescale 1ns/100ps
`default_nettype none

module dram_mode_register_set
    import dram_mode_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Command and address bus
    input  wire logic        chipSelect_n,
    input  wire logic        rowStrobe_n,
    input  wire logic        colStrobe_n,
    input  wire logic        writeEnable_n,
    input  wire logic        clockEnable,
    input  wire logic [1:0]  bankAddr,
    input  wire logic [11:0] addr,
    // Power events from command decode
    input  wire logic        prechargePowerDown,
    input  wire logic        powerDownExit,
    input  wire logic        selfRefreshEntry,
    input  wire logic        selfRefreshExit,
    // Mode fields
    output logic [2:0]       burstCode,
    output logic [3:0]       read_delay_setting,
    output logic [3:0]       write_delay_setting,
    output logic             testMode,
    output logic             dllResetBit,
    output logic             modeBusy,
    output logic             latencyLegal,
    // Extended fields
    output logic [1:0]       driveStrength,
    output logic [1:0]       data_term_select,
    output logic [1:0]       driver_impedance_select,
    output logic [1:0]       added_read_delay,
    output logic             vendorIdEnable,
    output logic             lowPowerEnable,
    output logic             extBusy,
    // Derived controls
    output logic [4:0]       totalReadDelay,
    output logic             rxAlwaysOn,
    output logic             termEnable,
    output logic             term120,
    output logic             impedanceAutoCal,
    output logic             dllEnabled,
    output logic             low_power_state_one,
    output logic             low_power_state_two,
    output logic             longLowPower,
    // Identification onto the data pins
    output logic [7:0]       idData,
    output logic             idDataOe
);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic       loadCmd;
    logic       mode_load_cmd;
    logic       ext_mode_load_cmd;
    logic [3:0] next_read;
    logic [3:0] next_write;

    assign loadCmd = !chipSelect_n && !rowStrobe_n && !colStrobe_n
                     && !writeEnable_n;
    assign mode_load_cmd     = loadCmd && bankAddr == 2'h0;
    assign ext_mode_load_cmd = loadCmd && bankAddr == 2'h1;

    // Latency codes are taken as the clock count itself
    assign next_read  = {1'b0, addr[MR_READ_LSB +: 3]};
    assign next_write = {1'b0, addr[MR_WRITE_LSB +: 3]};

    function automatic logic inRange(input logic [3:0] v,
                                     input logic [3:0] lo,
                                     input logic [3:0] hi);
        inRange = v >= lo && v <= hi;
    endfunction

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            burstCode           <= 3'h2;
            read_delay_setting  <= READ_DELAY_RST;
            write_delay_setting <= WRITE_DELAY_RST;
            testMode            <= 1'b0;
            latencyLegal        <= 1'b1;
        end
        else if (mode_load_cmd)
        begin
            burstCode           <= addr[MR_BURST_LSB +: 3];
            read_delay_setting  <= next_read;
            write_delay_setting <= next_write;
            testMode            <= addr[MR_TEST_BIT];
            // Reserved codes are stored but flagged
            latencyLegal <= inRange(next_read, READ_DELAY_MIN,
                                    READ_DELAY_MAX)
                            && inRange(next_write, WRITE_DELAY_MIN,
                                       WRITE_DELAY_MAX);
        end
    end

    // ------------------------------------------------------------
    // DLL reset with self-clearing bit
    // ------------------------------------------------------------
    logic [3:0] dllCount;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dllResetBit <= 1'b0;
            dllCount    <= 4'h0;
        end
        else if (mode_load_cmd && addr[MR_DLLRST_BIT])
        begin
            dllResetBit <= 1'b1;
            dllCount    <= 4'(DLL_RESET_CYCLES - 1);
        end
        else if (dllResetBit)
        begin
            if (dllCount == 4'h0)
                dllResetBit <= 1'b0;
            else
                dllCount <= dllCount - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Load completion timers
    // ------------------------------------------------------------
    logic [2:0] modeCount;
    logic [2:0] extCount;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            modeCount <= 3'h0;
            modeBusy  <= 1'b0;
        end
        else if (mode_load_cmd)
        begin
            modeCount <= 3'(MODE_LOAD_CYCLES - 1);
            modeBusy  <= 1'b1;
        end
        else if (modeCount != 3'h0)
            modeCount <= modeCount - 3'h1;
        else
            modeBusy <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            extCount <= 3'h0;
            extBusy  <= 1'b0;
        end
        else if (ext_mode_load_cmd)
        begin
            extCount <= 3'(MODE_LOAD_CYCLES - 1);
            extBusy  <= 1'b1;
        end
        else if (extCount != 3'h0)
            extCount <= extCount - 3'h1;
        else
            extBusy <= 1'b0;
    end

    // ------------------------------------------------------------
    // Extended mode register
    // ------------------------------------------------------------
    logic dllOffReq;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            driveStrength           <= 2'h0;
            data_term_select        <= TERM_OFF;
            added_read_delay        <= 2'h0;
            dllOffReq               <= 1'b0;
            driver_impedance_select <= IMP_AUTOCAL;
            vendorIdEnable          <= 1'b0;
            lowPowerEnable          <= 1'b0;
        end
        else if (ext_mode_load_cmd)
        begin
            driveStrength    <= addr[EMR_DRIVE_LSB +: 2];
            data_term_select <= addr[EMR_TERM_LSB +: 2];
            added_read_delay <= addr[EMR_ADDED_LSB +: 2];
            dllOffReq        <= addr[EMR_DLLOFF_BIT];
            driver_impedance_select <= addr[EMR_IMP_LSB +: 2];
            vendorIdEnable   <= addr[EMR_VENDOR_BIT];
            lowPowerEnable   <= addr[EMR_LOWPWR_BIT];
        end
        else if (selfRefreshExit)
            dllOffReq <= 1'b0;
    end

    // ------------------------------------------------------------
    // Derived controls
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            totalReadDelay   <= 5'h0;
            rxAlwaysOn       <= 1'b0;
            termEnable       <= 1'b0;
            term120          <= 1'b0;
            impedanceAutoCal <= 1'b0;
            idData           <= 8'h00;
            idDataOe         <= 1'b0;
        end
        else
        begin
            totalReadDelay <= {1'b0, read_delay_setting}
                              + {3'h0, added_read_delay};
            rxAlwaysOn <= write_delay_setting <= RX_ALWAYS_ON_MAX;
            termEnable <= data_term_select == TERM_60
                          || data_term_select == TERM_120;
            term120    <= data_term_select == TERM_120;
            impedanceAutoCal <= driver_impedance_select
                                == IMP_AUTOCAL;
            idData   <= {REV_CODE, MAKER_CODE};
            idDataOe <= vendorIdEnable;
        end
    end

    // ------------------------------------------------------------
    // Power state and DLL enable
    // ------------------------------------------------------------
    pwr_state_t pwrState;
    pwr_state_t next_pwrState;
    logic [11:0] lowPowerTime;

    always_comb
    begin
        next_pwrState = pwrState;
        unique case (pwrState)
            PWR_ACTIVE:
                if (prechargePowerDown)
                    next_pwrState = lowPowerEnable ? PWR_LP1 : PWR_PDN;
                else if (selfRefreshEntry)
                    next_pwrState = lowPowerEnable ? PWR_LP2 : PWR_SREF;
            PWR_PDN, PWR_LP1:
                if (powerDownExit)
                    next_pwrState = PWR_ACTIVE;
            PWR_SREF, PWR_LP2:
                if (selfRefreshExit)
                    next_pwrState = PWR_ACTIVE;
            default:
                next_pwrState = PWR_ACTIVE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            pwrState <= PWR_ACTIVE;
        else
            pwrState <= next_pwrState;
    end

    // Duration in low-power state picks the exit wait the controller needs
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            lowPowerTime <= 12'h000;
            longLowPower <= 1'b0;
        end
        else if (pwrState == PWR_ACTIVE && next_pwrState != PWR_ACTIVE)
        begin
            lowPowerTime <= 12'h000;
            longLowPower <= 1'b0;
        end
        else if (pwrState != PWR_ACTIVE)
        begin
            if (lowPowerTime == 12'(LP_LONG_CYCLES - 1))
                longLowPower <= 1'b1;
            else
                lowPowerTime <= lowPowerTime + 12'h001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dllEnabled          <= 1'b0;
            low_power_state_one <= 1'b0;
            low_power_state_two <= 1'b0;
        end
        else
        begin
            dllEnabled <= !dllOffReq && next_pwrState != PWR_LP1;
            low_power_state_one <= next_pwrState == PWR_LP1;
            low_power_state_two <= next_pwrState == PWR_LP2;
        end
    end

endmodule

`default_nettype wire

// *** tb/dram_mode_chk.sv ***
// Checker for the mode and extended-mode register set.
// Assumes one mclk domain and synchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
module dram_mode_chk
    import dram_mode_pkg::*;
(
    // Clock and bus
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        chipSelect_n,
    input wire logic        rowStrobe_n,
    input wire logic        colStrobe_n,
    input wire logic        writeEnable_n,
    input wire logic [1:0]  bankAddr,
    input wire logic [11:0] addr,
    input wire logic        prechargePowerDown,
    input wire logic        selfRefreshExit,
    // Outputs watched
    input wire logic [2:0]  burstCode,
    input wire logic [3:0]  read_delay_setting,
    input wire logic [3:0]  write_delay_setting,
    input wire logic        dllResetBit,
    input wire logic        modeBusy,
    input wire logic [1:0]  driveStrength,
    input wire logic [1:0]  added_read_delay,
    input wire logic        vendorIdEnable,
    input wire logic        lowPowerEnable,
    input wire logic        extBusy,
    input wire logic [4:0]  totalReadDelay,
    input wire logic        rxAlwaysOn,
    input wire logic        dllEnabled,
    input wire logic        low_power_state_one,
    input wire logic        low_power_state_two,
    input wire logic [7:0]  idData,
    input wire logic        idDataOe
);
    wire logic cmdLow = !chipSelect_n && !rowStrobe_n && !colStrobe_n
        && !writeEnable_n;
    wire logic modeCmd = cmdLow && bankAddr == 2'h0;
    wire logic extCmd = cmdLow && bankAddr == 2'h1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_mode_fields;
        modeCmd |=> read_delay_setting == {1'b0, $past(addr[6:4])}
            && write_delay_setting == {1'b0, $past(addr[11:9])}
            && burstCode == $past(addr[2:0]);
    endproperty
    a_mode_fields: assert property (p_mode_fields)
        else $error("mode fields wrong");
    property p_dll_set;
        modeCmd && addr[8] |=> dllResetBit[*8] ##1 dllResetBit
            ##1 dllResetBit ##1 !dllResetBit;
    endproperty
    a_dll_set: assert property (p_dll_set)
        else $error("dll reset bit timing wrong");
    property p_ext_fields;
        extCmd |=> driveStrength == $past(addr[1:0])
            && added_read_delay == $past(addr[5:4])
            && lowPowerEnable == $past(addr[11]);
    endproperty
    a_ext_fields: assert property (p_ext_fields)
        else $error("ext fields wrong");
    property p_ext_busy;
        extCmd |=> extBusy[*6] ##1 !extBusy;
    endproperty
    a_ext_busy: assert property (p_ext_busy)
        else $error("ext busy span wrong");
    property p_mode_busy;
        modeCmd |=> modeBusy[*6] ##1 !modeBusy;
    endproperty
    a_mode_busy: assert property (p_mode_busy)
        else $error("mode busy span wrong");
    property p_rx;
        modeCmd |=> ##1 rxAlwaysOn == ($past(addr[11:9], 2) <= 3'h3);
    endproperty
    a_rx: assert property (p_rx)
        else $error("receiver enable wrong");
    property p_total;
        $stable(read_delay_setting) && $stable(added_read_delay) |=>
            totalReadDelay == 5'($past(read_delay_setting))
            + 5'($past(added_read_delay));
    endproperty
    a_total: assert property (p_total)
        else $error("total read delay wrong");
    property p_vendor;
        $rose(vendorIdEnable) |=> idDataOe && idData == {REV_CODE, MAKER_CODE};
    endproperty
    a_vendor: assert property (p_vendor)
        else $error("id readout wrong");
    property p_lp1;
        prechargePowerDown && lowPowerEnable && !low_power_state_one
            && !low_power_state_two |=> low_power_state_one && !dllEnabled;
    endproperty
    a_lp1: assert property (p_lp1)
        else $error("low power entry wrong");
    property p_dll_back;
        selfRefreshExit && low_power_state_two |-> ##[1:3] dllEnabled;
    endproperty
    a_dll_back: assert property (p_dll_back)
        else $error("dll not back on");
    c_dll: cover property (modeCmd && addr[8]);
    c_id: cover property (extCmd && addr[10]);
    c_sref: cover property (selfRefreshExit && low_power_state_two);
endmodule
bind dram_mode_register_set dram_mode_chk dram_mode_chk_i (
    .mclk(mclk), .rst(rst), .chipSelect_n(chipSelect_n),
    .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .writeEnable_n(writeEnable_n), .bankAddr(bankAddr), .addr(addr),
    .prechargePowerDown(prechargePowerDown),
    .selfRefreshExit(selfRefreshExit), .burstCode(burstCode),
    .read_delay_setting(read_delay_setting),
    .write_delay_setting(write_delay_setting),
    .dllResetBit(dllResetBit), .modeBusy(modeBusy),
    .driveStrength(driveStrength), .added_read_delay(added_read_delay),
    .vendorIdEnable(vendorIdEnable), .lowPowerEnable(lowPowerEnable),
    .extBusy(extBusy), .totalReadDelay(totalReadDelay),
    .rxAlwaysOn(rxAlwaysOn), .dllEnabled(dllEnabled),
    .low_power_state_one(low_power_state_one),
    .low_power_state_two(low_power_state_two), .idData(idData),
    .idDataOe(idDataOe));
`default_nettype wire

// *** tb/mode_ctrl_model.sv ***
// Controller model driving command bus and power events.
// Assumes mclk from the bench; drives 1 ns after each rising edge.
`timescale 1ns/100ps
`default_nettype none
module mode_ctrl_model
(
    // Clock
    input wire logic   mclk,
    // Command bus
    output logic       chipSelect_n,
    output logic       rowStrobe_n,
    output logic       colStrobe_n,
    output logic       writeEnable_n,
    output logic       clockEnable,
    output logic [1:0] bankAddr,
    output logic [11:0] addr,
    // Power events
    output logic       prechargePowerDown,
    output logic       powerDownExit,
    output logic       selfRefreshEntry,
    output logic       selfRefreshExit
);
    // Idle levels, set once by the bench at time zero
    task automatic park();
        {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 4'hf;
        clockEnable = 1'b1;
        bankAddr = 2'h0;
        addr = 12'h000;
        {prechargePowerDown, powerDownExit,
            selfRefreshEntry, selfRefreshExit} = 4'h0;
    endtask
    // Deselected: address lines churn every cycle
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 4'hf;
            addr = ~addr;
            bankAddr = ~bankAddr;
        end
    endtask
    // Load issued only with banks idle
    task automatic load(input logic [1:0] ba, input logic [11:0] a);
        @(posedge mclk);
        #1;
        {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 4'h0;
        bankAddr = ba;
        addr = a;
        idle(1);
    endtask
    // 0 pdn entry, 1 pdn exit, 2 sref entry, 3 sref exit
    task automatic pulse(input int which);
        @(posedge mclk);
        #1;
        {prechargePowerDown, powerDownExit,
            selfRefreshEntry, selfRefreshExit} = 4'h8 >> which;
        @(posedge mclk);
        #1;
        {prechargePowerDown, powerDownExit,
            selfRefreshEntry, selfRefreshExit} = 4'h0;
    endtask
endmodule
`default_nettype wire

// *** tb/dram_mode_register_set_tb_top.sv ***
// Bench for the mode register set: loads, then power events.
// Assumes the controller model sits on the command side.
`timescale 1ns/100ps
`default_nettype none
module dram_mode_register_set_tb_top
    import dram_mode_pkg::*;
;
    logic mclk, rst, csN, rasN, casN, weN, cke, pdn, pdx, sre, srx;
    logic [1:0] ba, drv, trm, imp, add;
    logic [11:0] a;
    logic [2:0] burst;
    logic [3:0] rd, wr;
    logic [4:0] tot;
    logic [7:0] idd;
    logic tm, dllr, legal, rxOn, tEn, t120, aCal, dllOn, lp1, lp2, lng, oe;
    logic mBusy, eBusy, vEn, lpEn;
    int error_cnt = 0;
    int tests_run = 0;
    mode_ctrl_model mode_ctrl_model_i (.mclk(mclk), .chipSelect_n(csN),
        .rowStrobe_n(rasN), .colStrobe_n(casN), .writeEnable_n(weN),
        .clockEnable(cke), .bankAddr(ba), .addr(a),
        .prechargePowerDown(pdn), .powerDownExit(pdx),
        .selfRefreshEntry(sre), .selfRefreshExit(srx));
    dram_mode_register_set dram_mode_register_set_i (.mclk(mclk), .rst(rst),
        .chipSelect_n(csN), .rowStrobe_n(rasN), .colStrobe_n(casN),
        .writeEnable_n(weN), .clockEnable(cke), .bankAddr(ba), .addr(a),
        .prechargePowerDown(pdn), .powerDownExit(pdx),
        .selfRefreshEntry(sre), .selfRefreshExit(srx), .burstCode(burst),
        .read_delay_setting(rd), .write_delay_setting(wr), .testMode(tm),
        .dllResetBit(dllr), .modeBusy(mBusy), .latencyLegal(legal),
        .driveStrength(drv), .data_term_select(trm),
        .driver_impedance_select(imp), .added_read_delay(add),
        .vendorIdEnable(vEn), .lowPowerEnable(lpEn), .extBusy(eBusy),
        .totalReadDelay(tot), .rxAlwaysOn(rxOn), .termEnable(tEn),
        .term120(t120), .impedanceAutoCal(aCal), .dllEnabled(dllOn),
        .low_power_state_one(lp1), .low_power_state_two(lp2),
        .longLowPower(lng), .idData(idd), .idDataOe(oe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        repeat (30000) @(posedge mclk);
        error_cnt++;
        give_verdict();
    end
    initial
    begin
        logic [3:0] r, w;
        logic [1:0] k;
        rst = 1'b1;
        mode_ctrl_model_i.park();
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        check(16'(rd), 16'(READ_DELAY_RST));
        check(16'(wr), 16'(WRITE_DELAY_RST));
        // Legal latency codes, test mode both ways
        for (int i = 0; i < 6; i++)
        begin
            r = 4'(5 + i % 3);
            w = 4'(1 + i);
            mode_ctrl_model_i.load(2'h0, {w[2:0], 1'b0, 1'(i), r[2:0], 4'h2});
            check(16'(rd), 16'(r));
            check(16'(wr), 16'(w));
            check(16'(tm), 16'(i % 2));
            check(16'(burst), 16'h2);
            check(16'(mBusy), 16'h1);
            mode_ctrl_model_i.idle(1);
            check(16'(rxOn), 16'(w <= 4'h3));
            check(16'(tot), 16'(r));
            check(16'(legal), 16'h1);
            mode_ctrl_model_i.idle(6);
            check(16'(mBusy), 16'h0);
        end
        // Reserved codes are flagged
        mode_ctrl_model_i.load(2'h0, 12'he32);
        mode_ctrl_model_i.idle(1);
        check(16'(legal), 16'h0);
        mode_ctrl_model_i.idle(6);
        mode_ctrl_model_i.load(2'h0, 12'h562);
        check(16'(dllr), 16'h1);
        mode_ctrl_model_i.idle(12);
        check(16'(dllr), 16'h0);
        check(16'(rd), 16'h6);
        // Extended fields, every code
        for (int i = 0; i < 4; i++)
        begin
            k = 2'(i);
            mode_ctrl_model_i.load(2'h1, {2'h0, k, 2'h0, k, k, k});
            check(16'(drv), 16'(k));
            check(16'(eBusy), 16'h1);
            check(16'(trm), 16'(k));
            check(16'(imp), 16'(k));
            check(16'(rd), 16'h6);
            mode_ctrl_model_i.idle(1);
            check(16'(tEn), 16'(k == 2'h1 || k == 2'h2));
            check(16'(t120), 16'(k == 2'h2));
            check(16'(aCal), 16'(k == IMP_AUTOCAL));
            check(16'(tot), 16'(6 + i));
            mode_ctrl_model_i.idle(6);
            check(16'(eBusy), 16'h0);
        end
        mode_ctrl_model_i.load(2'h2, 12'h001);
        check(16'(drv), 16'h3);
        mode_ctrl_model_i.idle(6);
        mode_ctrl_model_i.load(2'h1, 12'h400);
        check(16'(vEn), 16'h1);
        mode_ctrl_model_i.idle(1);
        check(16'(oe), 16'h1);
        check(16'(idd), 16'({REV_CODE, MAKER_CODE}));
        mode_ctrl_model_i.idle(6);
        mode_ctrl_model_i.load(2'h1, 12'h000);
        mode_ctrl_model_i.idle(1);
        check(16'(oe), 16'h0);
        mode_ctrl_model_i.idle(6);
        // Power-down with low power off, then on with DLL off
        mode_ctrl_model_i.pulse(0);
        check(16'(lp1), 16'h0);
        mode_ctrl_model_i.pulse(1);
        mode_ctrl_model_i.load(2'h1, 12'h840);
        check(16'(lpEn), 16'h1);
        mode_ctrl_model_i.idle(6);
        mode_ctrl_model_i.pulse(0);
        check(16'(lp1), 16'h1);
        check(16'(dllOn), 16'h0);
        mode_ctrl_model_i.idle(2100);
        check(16'(lng), 16'h1);
        mode_ctrl_model_i.pulse(1);
        check(16'(lp1), 16'h0);
        mode_ctrl_model_i.idle(LP_LONG_EXIT_TCK);
        mode_ctrl_model_i.pulse(2);
        check(16'(lp2), 16'h1);
        mode_ctrl_model_i.idle(10);
        mode_ctrl_model_i.pulse(3);
        mode_ctrl_model_i.idle(2);
        check(16'(lp2), 16'h0);
        check(16'(dllOn), 16'h1);
        mode_ctrl_model_i.idle(LP_SHORT_EXIT_TCK);
        give_verdict();
    end
endmodule
`default_nettype wire
